// File: dv/afe_control_and_output_coding_tb_top.sv
// Self-checking bench for the front-end control block and its output coder.
// Assumes the package, interface and design files are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module afe_control_and_output_coding_tb_top;
  import afc_pkg::*;

  localparam longint HALF = 64'sh0000_0000_0080_0000;
  localparam longint FULL = 64'sh0000_0000_00FF_FFFF;

  logic               core_clk     = 1'b0;
  logic               reset        = 1'b1;
  logic               reg_wr       = 1'b0;
  logic               reg_rd       = 1'b0;
  afc_addr_t          reg_addr     = 8'h00;
  afc_word_t          reg_wdata    = 24'h00_0000;
  logic [2:0]         setup_sel    = 3'h0;
  logic               sync_n       = 1'b1;
  logic               sample_valid = 1'b0;
  logic signed [25:0] sample_value = 26'h000_0000;
  logic               reg_rvalid;
  afc_word_t          reg_rdata;
  logic               mod_filter_reset;
  logic [2:0]         gain_code;
  logic               amp_stage1_en;
  logic               amp_stage2_en;
  logic               pos_input_buffer_enable;
  logic               neg_input_buffer_enable;
  logic [1:0]         ref_source;
  logic               vref_power_en;
  logic [2:0]         excite_a_magnitude;
  logic [2:0]         excite_b_magnitude;
  logic [3:0]         excite_a_pin_select;
  logic [3:0]         excite_b_pin_select;
  logic               bridge_switch_enable;
  logic [3:0]         gp_output_pins;
  logic [3:0]         gp_output_pins_oe;
  logic               result_valid;
  logic [23:0]        result_code;
  int                 n_mismatch   = 0;
  int                 checked      = 0;
  int                 mr_cnt       = 0;
  logic [31:0]        rng          = 32'h0000_f25f;

  // Free-running core clock.
  always #25 core_clk = ~core_clk;

  // Counts high cycles of the modulator reset at mid-cycle, so a pulse is never counted twice.
  always @(negedge core_clk) begin
    if (mod_filter_reset === 1'b1) mr_cnt++;
  end

  afc_ctrl i_afc_ctrl (
    .core_clk                (core_clk),
    .reset                   (reset),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_rvalid              (reg_rvalid),
    .reg_rdata               (reg_rdata),
    .setup_sel               (setup_sel),
    .sync_n                  (sync_n),
    .mod_filter_reset        (mod_filter_reset),
    .gain_code               (gain_code),
    .amp_stage1_en           (amp_stage1_en),
    .amp_stage2_en           (amp_stage2_en),
    .pos_input_buffer_enable (pos_input_buffer_enable),
    .neg_input_buffer_enable (neg_input_buffer_enable),
    .ref_source              (ref_source),
    .vref_power_en           (vref_power_en),
    .excite_a_magnitude      (excite_a_magnitude),
    .excite_b_magnitude      (excite_b_magnitude),
    .excite_a_pin_select     (excite_a_pin_select),
    .excite_b_pin_select     (excite_b_pin_select),
    .bridge_switch_enable    (bridge_switch_enable),
    .gp_output_pins          (gp_output_pins),
    .gp_output_pins_oe       (gp_output_pins_oe),
    .sample_valid            (sample_valid),
    .sample_value            (sample_value),
    .result_valid            (result_valid),
    .result_code             (result_code)
  );

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Fixed-seed xorshift, so every run replays the same stimulus.
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  // Coding model: offset binary or doubled straight binary, clamped instead of wrapped.
  function automatic logic [23:0] code_of(input longint x, input bit bip);
    longint e;
    e = bip ? x + HALF : 2 * x;
    if (e < 0) e = 0;
    if (e > FULL) e = FULL;
    return e[23:0];
  endfunction : code_of

  // One write; waits long enough for outputs to follow and for any reset pulse to be counted.
  task automatic wr(input afc_addr_t a, input afc_word_t d);
    @(posedge core_clk);
    mr_cnt = 0;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : wr

  // One read; the answer stands for a single cycle, so it is taken right after the answering edge.
  task automatic rd(input afc_addr_t a, output afc_word_t d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid, 1'b1);
    d = reg_rdata;
  endtask : rd

  // Back-to-back samples; each result is checked in the cycle it stands.
  task automatic burst(input int vals[$], input bit bip);
    logic [23:0] q[$];
    foreach (vals[i]) begin
      @(posedge core_clk);
      sample_valid <= 1'b1;
      sample_value <= vals[i][25:0];
      #1;
      if (i > 0) chk(result_code, q[i-1]);
      q.push_back(code_of(vals[i], bip));
    end
    @(posedge core_clk);
    sample_valid <= 1'b0;
    #1;
    chk(result_valid, 1'b1);
    chk(result_code, q[$]);
  endtask : burst

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // A hang is cut short well past the expected few hundred cycles.
  initial begin
    #(50 * 20000);
    n_mismatch++;
    finish_test();
  end

  // Main sequence.
  initial begin
    int          vals[$];
    afc_word_t   w;
    afc_word_t   r;
    logic [31:0] tmp;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk({amp_stage2_en, amp_stage1_en}, 2'b00);
    chk({pos_input_buffer_enable, neg_input_buffer_enable}, 2'b11);
    chk(vref_power_en, 1'b0);
    chk(gp_output_pins_oe, 4'h0);
    rd(8'h03, r);
    chk(r, 24'h00_0000);
    rd(8'h19, r);
    chk(r, 24'h00_0860);
    // Every gain code and reference field, with reserved bits set and buffers requested off.
    for (int i = 0; i < 8; i++) begin
      w = 24'hFF_F000 | {19'h0_0000, i[1:0], i[2:0]};
      wr(8'h19, w);
      chk(24'(mr_cnt), 24'h00_0001);
      chk(gain_code, i[2:0]);
      chk({amp_stage2_en, amp_stage1_en}, {i > 3, i > 0});
      chk({pos_input_buffer_enable, neg_input_buffer_enable}, {i > 0, i > 0});
      chk(ref_source, i[1:0]);
      rd(8'h19, r);
      chk(r, w & 24'h00_0FFF);
    end
    wr(8'h19, 24'h00_0040);
    chk({pos_input_buffer_enable, neg_input_buffer_enable}, 2'b10);
    wr(8'h01, 24'hFF_FFFF);
    chk(vref_power_en, 1'b1);
    chk(24'(mr_cnt), 24'h00_0001);
    rd(8'h01, r);
    chk(r, 24'h00_3FFF);
    wr(8'h02, 24'hFF_FFFF);
    chk(24'(mr_cnt), 24'h00_0000);
    rd(8'h02, r);
    chk(r, 24'h00_0000);
    // Input/output control: random words, a shared pin, off and full magnitudes, reference on then off.
    for (int i = 0; i < 8; i++) begin
      tmp = xs();
      w = tmp[23:0];
      if (i == 0) w[13:8] = 6'h38;
      if (i == 2) w[7:4] = w[3:0];
      if (i == 4) wr(8'h01, 24'h00_0000);
      wr(8'h03, w);
      chk(24'(mr_cnt), 24'h00_0000);
      chk(vref_power_en, i < 4);
      chk(excite_a_magnitude, w[10:8]);
      chk(excite_b_magnitude, w[13:11]);
      chk(excite_a_pin_select, w[3:0]);
      chk(excite_b_pin_select, w[7:4]);
      chk(bridge_switch_enable, w[15]);
      chk(gp_output_pins_oe, w[19:16]);
      chk(gp_output_pins, w[23:20] & w[19:16]);
      rd(8'h03, r);
      chk(r, w & 24'hFF_BFFF);
    end
    // Sync pin held low for one and for three edges.
    for (int k = 1; k <= 3; k += 2) begin
      @(posedge core_clk);
      mr_cnt = 0;
      sync_n <= 1'b0;
      repeat (k) @(posedge core_clk);
      sync_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk(24'(mr_cnt), 24'(k));
    end
    // Coding through setup one, unipolar then bipolar, with boundary and random samples.
    for (int b = 0; b < 2; b++) begin
      wr(8'h1A, {12'h000, b[0], 11'h000});
      @(posedge core_clk);
      setup_sel <= 3'h1;
      repeat (2) @(posedge core_clk);
      #1;
      chk({pos_input_buffer_enable, neg_input_buffer_enable}, 2'b00);
      vals = '{32'sh0000_0000, 32'sh0040_0000, 32'sh007F_FFFF, 32'sh0080_0000,
               -32'sh0000_0001, -32'sh0080_0000, -32'sh0080_0001, 32'sh01FF_FFFF};
      repeat (4) begin
        tmp = xs();
        vals.push_back(int'($signed(tmp[25:0])));
      end
      burst(vals, b[0]);
    end
    finish_test();
  end

endmodule : afe_control_and_output_coding_tb_top

`default_nettype wire

// File: include/afc_code_if.sv
// Carrier between the control module and the output coder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface afc_code_if #(parameter int IN_W = 26, parameter int CODE_W = 24);
  logic                   sample_valid;
  logic signed [IN_W-1:0] sample_value;
  logic                   bipolar;
  logic                   code_valid;
  logic [CODE_W-1:0]      code;

  modport ctrl  (output sample_valid, output sample_value, output bipolar, input code_valid, input code);
  modport coder (input sample_valid, input sample_value, input bipolar, output code_valid, output code);
endinterface : afc_code_if

`default_nettype wire

// File: include/afc_consts.svh
// Register indices, field positions, reset values and masks of the front-end control block.
// Assumes it is included by bare name from the package and the control module.
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH

// Register indices as they appear on the register port.
`define AFC_IDX_ADC_CTRL   8'h01
`define AFC_IDX_IO_CTRL1   8'h03
`define AFC_IDX_CFG_FIRST  8'h19
`define AFC_IDX_CFG_LAST   8'h20

// Reset values.
`define AFC_RST_ADC_CTRL   16'h0000
`define AFC_RST_IO_CTRL1   24'h00_0000
`define AFC_RST_CFG        16'h0860

// Writable bits; the rest read as zero.
`define AFC_MASK_ADC_CTRL  16'h3FFF
`define AFC_MASK_IO_CTRL1  24'hFF_BFFF
`define AFC_MASK_CFG       16'h0FFF

// Converter control fields.
`define AFC_ADC_REF_EN     8

// Per-setup configuration fields.
`define AFC_CFG_BIPOLAR    11
`define AFC_CFG_POS_INPUT_BUFFER_ENABLE   6
`define AFC_CFG_NEG_INPUT_BUFFER_ENABLE   5
`define AFC_CFG_REF_SEL_HI 4
`define AFC_CFG_REF_SEL_LO 3
`define AFC_CFG_GAIN_HI    2
`define AFC_CFG_GAIN_LO    0

// Input/output control fields.
`define AFC_IO_GP_DATA_HI  23
`define AFC_IO_GP_DATA_LO  20
`define AFC_IO_GP_EN_HI    19
`define AFC_IO_GP_EN_LO    16
`define AFC_IO_BRIDGE      15
`define AFC_IO_EXB_MAG_HI  13
`define AFC_IO_EXB_MAG_LO  11
`define AFC_IO_EXA_MAG_HI  10
`define AFC_IO_EXA_MAG_LO  8
`define AFC_IO_EXB_PIN_HI  7
`define AFC_IO_EXB_PIN_LO  4
`define AFC_IO_EXA_PIN_HI  3
`define AFC_IO_EXA_PIN_LO  0

// Gain code thresholds: 0 is unity, 1..3 is two to eight.
`define AFC_GAIN_UNITY     3'h0
`define AFC_GAIN_ONE_STAGE 3'h3

`endif

// File: include/afc_pkg.sv
// Types shared by the front-end control block and its output coder.
// Assumes afc_consts.svh is reachable on the include path.
`include "afc_consts.svh"

package afc_pkg;

  typedef logic [7:0]  afc_addr_t;
  typedef logic [23:0] afc_word_t;
  typedef logic [15:0] afc_cfg_t;

  // Whole state of the control module.
  typedef struct packed {
    logic [15:0]      adc_ctrl;
    logic [23:0]      io_ctrl1;
    logic [7:0][15:0] cfg;
    logic [23:0]      rdata;
    logic             rvalid;
    logic [2:0]       gain_code;
    logic             stage1_en;
    logic             stage2_en;
    logic             pos_buf_en;
    logic             neg_buf_en;
    logic [1:0]       ref_source;
    logic             vref_power_en;
    logic             bipolar;
    logic [2:0]       exa_mag;
    logic [2:0]       exb_mag;
    logic [3:0]       exa_pin;
    logic [3:0]       exb_pin;
    logic             bridge_en;
    logic [3:0]       gp_o;
    logic [3:0]       gp_oe;
    logic             mod_reset;
  } afc_ctrl_s;

  // Whole state of the output coder.
  typedef struct packed {
    logic        valid;
    logic [23:0] code;
  } afc_coder_s;

endpackage : afc_pkg

// File: logic/afc_coder.sv
// Output coder: turns a signed scaled sample into a straight or offset binary result.
// Assumes the sample is input times gain over reference, scaled by two to the CODE_W-1.
`timescale 1ns/1ps
`default_nettype none

module afc_coder #(
  parameter int IN_W   = 26,
  parameter int CODE_W = 24
) (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic reset,
  // Sample in, code out.
  afc_code_if.coder cif
);
  import afc_pkg::*;

  localparam logic signed [IN_W+1:0] HALF = (IN_W+2)'(1) <<< (CODE_W-1);
  localparam logic signed [IN_W+1:0] TOP  = ((IN_W+2)'(1) <<< CODE_W) - (IN_W+2)'(1);

  // The clamp needs at least one guard bit above the code; other code widths are not served.
  if (IN_W < CODE_W + 1 || CODE_W != 24) begin : g_bad_widths
    $error("afc_coder: unsupported widths");
  end

  afc_coder_s st_reg;
  afc_coder_s st_next;
  logic signed [IN_W+1:0] ext;
  logic signed [IN_W+1:0] sum;

  // Unipolar doubles the sample, bipolar adds half scale; both clamp instead of wrapping.
  always_comb begin
    ext = (IN_W+2)'(cif.sample_value);
    sum = cif.bipolar ? ext + HALF : ext <<< 1;
    st_next = st_reg;
    st_next.valid = cif.sample_valid;
    if (cif.sample_valid) begin
      if (sum < 0) begin
        st_next.code = '0;
      end else if (sum > TOP) begin
        st_next.code = '1;
      end else begin
        st_next.code = sum[CODE_W-1:0];
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cif.code_valid = st_reg.valid;
  assign cif.code       = st_reg.code;

  chk_bipolar_zero_mid: assert property (@(posedge core_clk) disable iff (reset)
    cif.sample_valid && cif.bipolar && cif.sample_value == 0 |=> cif.code == 24'h80_0000)
    else $error("bipolar zero input did not give midscale");
  chk_code_no_wrap: assert property (@(posedge core_clk) disable iff (reset)
    cif.sample_valid && cif.sample_value < 0 && !cif.bipolar |=> cif.code == 24'h00_0000)
    else $error("negative unipolar input did not clamp to zero");
endmodule : afc_coder

`default_nettype wire

// File: logic/afc_ctrl.sv
// Front-end control block: gain, buffers, reference, excitation, bridge switch,
// general-purpose outputs, modulator reset and result coding.
// Assumes a synchronous register port, and sync_n and setup_sel synchronous to core_clk.
// Contract
// - Eight gains, one to 128, per setup.
// - Unity bypasses stages; 2-8 one; above both.
// - Buffers optional at unity, forced above it.
// - Reference enable bit powers internal reference.
// - Setup field picks internal or external reference.
// - Setup bit picks unipolar or bipolar range.
// - Unipolar result is straight binary.
// - Bipolar result is offset binary.
// - 24-bit code scales with gain over reference.
// - Two excitation sources, seven magnitudes or off.
// - Each source has own magnitude and pin.
// - Both sources may share one pin.
// - Excitation ignores reference enable bit.
// - Bridge bit closes low-side switch.
// - Each output driven only when enabled.
// - Enabled output drives its data bit.
// - Sync pulse or setup write resets modulator.
`timescale 1ns/1ps
`default_nettype none
`include "afc_consts.svh"

module afc_ctrl #(
  parameter int IN_W   = 26,
  parameter int CODE_W = 24
) (
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // Register port.
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire afc_pkg::afc_addr_t     reg_addr,
  input  wire afc_pkg::afc_word_t     reg_wdata,
  output logic                        reg_rvalid,
  output afc_pkg::afc_word_t          reg_rdata,
  // Sequencer and sync pin.
  input  wire logic [2:0]             setup_sel,
  input  wire logic                   sync_n,
  output logic                        mod_filter_reset,
  // Gain amplifier and input buffers.
  output logic [2:0]                  gain_code,
  output logic                        amp_stage1_en,
  output logic                        amp_stage2_en,
  output logic                        pos_input_buffer_enable,
  output logic                        neg_input_buffer_enable,
  // Reference.
  output logic [1:0]                  ref_source,
  output logic                        vref_power_en,
  // Excitation and bridge switch.
  output logic [2:0]                  excite_a_magnitude,
  output logic [2:0]                  excite_b_magnitude,
  output logic [3:0]                  excite_a_pin_select,
  output logic [3:0]                  excite_b_pin_select,
  output logic                        bridge_switch_enable,
  // General-purpose outputs.
  output logic [3:0]                  gp_output_pins,
  output logic [3:0]                  gp_output_pins_oe,
  // Filter samples and coded results.
  input  wire logic                   sample_valid,
  input  wire logic signed [IN_W-1:0] sample_value,
  output logic                        result_valid,
  output logic [CODE_W-1:0]           result_code
);
  import afc_pkg::*;

  // Refuse widths that the coder's clamp and the 24-bit register map cannot serve.
  if (CODE_W != 24 || IN_W < CODE_W + 1) begin : g_bad_widths
    $error("afc_ctrl: unsupported widths");
  end

  // True when the index falls in the per-setup configuration range.
  function automatic logic is_cfg(input afc_addr_t a);
    return a >= `AFC_IDX_CFG_FIRST && a <= `AFC_IDX_CFG_LAST;
  endfunction : is_cfg

  // Setup number of a configuration index.
  function automatic logic [2:0] cfg_slot(input afc_addr_t a);
    afc_addr_t d;
    d = a - `AFC_IDX_CFG_FIRST;
    return d[2:0];
  endfunction : cfg_slot

  afc_ctrl_s st_reg;
  afc_ctrl_s st_next;
  afc_cfg_t  cur_cfg;
  logic [2:0] cur_gain;
  logic      wr_adc;
  logic      wr_io;
  logic      wr_cfg;

  // Write strobes per register.
  assign wr_adc = reg_wr && reg_addr == `AFC_IDX_ADC_CTRL;
  assign wr_io  = reg_wr && reg_addr == `AFC_IDX_IO_CTRL1;
  assign wr_cfg = reg_wr && is_cfg(reg_addr);

  // The setup now in use; outputs follow it one cycle later.
  assign cur_cfg  = st_reg.cfg[setup_sel];
  assign cur_gain = cur_cfg[`AFC_CFG_GAIN_HI:`AFC_CFG_GAIN_LO];

  // Next-state logic for registers and all analog control outputs.
  always_comb begin
    st_next = st_reg;

    // Register writes; reserved bits are masked so they read back as zero.
    if (wr_adc) begin
      st_next.adc_ctrl = reg_wdata[15:0] & `AFC_MASK_ADC_CTRL;
    end
    if (wr_io) begin
      st_next.io_ctrl1 = reg_wdata & `AFC_MASK_IO_CTRL1;
    end
    if (wr_cfg) begin
      st_next.cfg[cfg_slot(reg_addr)] = reg_wdata[15:0] & `AFC_MASK_CFG;
    end

    // Reads answer one cycle later; an unmapped index reads as zero.
    st_next.rvalid = reg_rd;
    st_next.rdata  = '0;
    if (reg_rd) begin
      if (reg_addr == `AFC_IDX_ADC_CTRL) begin
        st_next.rdata = {8'h00, st_reg.adc_ctrl};
      end else if (reg_addr == `AFC_IDX_IO_CTRL1) begin
        st_next.rdata = st_reg.io_ctrl1;
      end else if (is_cfg(reg_addr)) begin
        st_next.rdata = {8'h00, st_reg.cfg[cfg_slot(reg_addr)]};
      end
    end

    // Amplifier stages and buffers from the active setup.
    st_next.gain_code  = cur_gain;
    st_next.stage1_en  = cur_gain != `AFC_GAIN_UNITY;
    st_next.stage2_en  = cur_gain > `AFC_GAIN_ONE_STAGE;
    st_next.pos_buf_en = cur_cfg[`AFC_CFG_POS_INPUT_BUFFER_ENABLE] || cur_gain != `AFC_GAIN_UNITY;
    st_next.neg_buf_en = cur_cfg[`AFC_CFG_NEG_INPUT_BUFFER_ENABLE] || cur_gain != `AFC_GAIN_UNITY;

    // Reference source and power; the reference must be powered by software when selected.
    st_next.ref_source    = cur_cfg[`AFC_CFG_REF_SEL_HI:`AFC_CFG_REF_SEL_LO];
    st_next.vref_power_en = st_reg.adc_ctrl[`AFC_ADC_REF_EN];
    st_next.bipolar       = cur_cfg[`AFC_CFG_BIPOLAR];

    // Excitation is not gated by the reference, and the pin fields are not cross-checked
    // so both sources may land on the same input.
    st_next.exa_mag = st_reg.io_ctrl1[`AFC_IO_EXA_MAG_HI:`AFC_IO_EXA_MAG_LO];
    st_next.exb_mag = st_reg.io_ctrl1[`AFC_IO_EXB_MAG_HI:`AFC_IO_EXB_MAG_LO];
    st_next.exa_pin = st_reg.io_ctrl1[`AFC_IO_EXA_PIN_HI:`AFC_IO_EXA_PIN_LO];
    st_next.exb_pin = st_reg.io_ctrl1[`AFC_IO_EXB_PIN_HI:`AFC_IO_EXB_PIN_LO];

    // Bridge switch and general-purpose outputs.
    st_next.bridge_en = st_reg.io_ctrl1[`AFC_IO_BRIDGE];
    st_next.gp_oe = st_reg.io_ctrl1[`AFC_IO_GP_EN_HI:`AFC_IO_GP_EN_LO];
    st_next.gp_o  = st_reg.io_ctrl1[`AFC_IO_GP_DATA_HI:`AFC_IO_GP_DATA_LO]
                    & st_reg.io_ctrl1[`AFC_IO_GP_EN_HI:`AFC_IO_GP_EN_LO];

    // Modulator and filter reset held while sync is low, pulsed by a mode or setup write.
    st_next.mod_reset = !sync_n || wr_adc || wr_cfg;
  end

  // State register.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg          <= '0;
      st_reg.adc_ctrl <= `AFC_RST_ADC_CTRL;
      st_reg.io_ctrl1 <= `AFC_RST_IO_CTRL1;
      st_reg.cfg      <= {8{`AFC_RST_CFG}};
    end else begin
      st_reg <= st_next;
    end
  end

  // Result coder, fed with the registered polarity of the active setup.
  afc_code_if #(.IN_W(IN_W), .CODE_W(CODE_W)) cif ();
  assign cif.sample_valid = sample_valid;
  assign cif.sample_value = sample_value;
  assign cif.bipolar      = st_reg.bipolar;

  afc_coder #(.IN_W(IN_W), .CODE_W(CODE_W)) u_coder (
    .core_clk (core_clk),
    .reset    (reset),
    .cif      (cif)
  );

  // Outputs, each straight from a flip-flop.
  assign reg_rvalid              = st_reg.rvalid;
  assign reg_rdata               = st_reg.rdata;
  assign mod_filter_reset        = st_reg.mod_reset;
  assign gain_code               = st_reg.gain_code;
  assign amp_stage1_en           = st_reg.stage1_en;
  assign amp_stage2_en           = st_reg.stage2_en;
  assign pos_input_buffer_enable = st_reg.pos_buf_en;
  assign neg_input_buffer_enable = st_reg.neg_buf_en;
  assign ref_source              = st_reg.ref_source;
  assign vref_power_en           = st_reg.vref_power_en;
  assign excite_a_magnitude      = st_reg.exa_mag;
  assign excite_b_magnitude      = st_reg.exb_mag;
  assign excite_a_pin_select     = st_reg.exa_pin;
  assign excite_b_pin_select     = st_reg.exb_pin;
  assign bridge_switch_enable    = st_reg.bridge_en;
  assign gp_output_pins          = st_reg.gp_o;
  assign gp_output_pins_oe       = st_reg.gp_oe;
  assign result_valid            = cif.code_valid;
  assign result_code             = cif.code;

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_unity_bypass: assert property (
    cur_gain == 3'h0 |=> !amp_stage1_en && !amp_stage2_en)
    else $error("unity gain did not bypass both stages");
  chk_one_stage: assert property (
    cur_gain inside {3'h1, 3'h2, 3'h3} |=> amp_stage1_en && !amp_stage2_en)
    else $error("gain two to eight did not use exactly one stage");
  chk_two_stages: assert property (
    cur_gain > 3'h3 |=> amp_stage1_en && amp_stage2_en)
    else $error("gain above eight did not use both stages");
  chk_buffer_forced: assert property (
    cur_gain != 3'h0 |=> pos_input_buffer_enable && neg_input_buffer_enable)
    else $error("buffers not forced on above unity gain");
  chk_ref_power: assert property (
    wr_adc |-> ##2 vref_power_en == $past(reg_wdata[`AFC_ADC_REF_EN], 2))
    else $error("reference power does not follow the enable bit");
  chk_excite_write: assert property (
    wr_io |-> ##2 excite_a_magnitude == $past(reg_wdata[10:8], 2)
                 && excite_b_pin_select == $past(reg_wdata[7:4], 2))
    else $error("excitation fields do not follow the written word");
  chk_bridge_switch: assert property (
    wr_io |-> ##2 bridge_switch_enable == $past(reg_wdata[15], 2))
    else $error("bridge switch does not follow its bit");
  chk_gp_drive: assert property (
    wr_io |-> ##2 gp_output_pins_oe == $past(reg_wdata[19:16], 2)
                 && (gp_output_pins & ~gp_output_pins_oe) == 4'h0)
    else $error("output enables or data wrong after a write");
  chk_sync_reset: assert property (
    !sync_n |=> mod_filter_reset)
    else $error("sync low did not reset the modulator");
  chk_cfg_reset: assert property (
    wr_cfg |=> mod_filter_reset)
    else $error("setup write did not reset the modulator");
  chk_unmapped_zero: assert property (
    reg_rd && !is_cfg(reg_addr) && reg_addr != 8'h01 && reg_addr != 8'h03 |=> reg_rdata == 24'h00_0000)
    else $error("unmapped read did not return zero");

  // Read port: one answer per strobe, and the data bus idles at zero between answers.
  chk_read_answer: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read strobe was not answered next cycle");
  chk_read_idle: assert property (
    !reg_rd |=> !reg_rvalid && reg_rdata == 24'h00_0000)
    else $error("read data stood without a read");

  // Setup-driven outputs follow the setup picked one edge earlier, so a setup change
  // mid-conversion shows at once; the sequencer is expected to switch between results.
  chk_gain_follow: assert property (
    1'b1 |=> gain_code == $past(cur_gain))
    else $error("gain code does not follow the active setup");
  chk_buffer_optional: assert property (
    cur_gain == 3'h0 |=> pos_input_buffer_enable == $past(cur_cfg[`AFC_CFG_POS_INPUT_BUFFER_ENABLE])
                         && neg_input_buffer_enable == $past(cur_cfg[`AFC_CFG_NEG_INPUT_BUFFER_ENABLE]))
    else $error("unity gain buffers do not follow their enable bits");
  chk_ref_select: assert property (
    1'b1 |=> ref_source == $past(cur_cfg[`AFC_CFG_REF_SEL_HI:`AFC_CFG_REF_SEL_LO]))
    else $error("reference source does not follow the active setup");
  chk_polarity: assert property (
    1'b1 |=> cif.bipolar == $past(cur_cfg[`AFC_CFG_BIPOLAR]))
    else $error("polarity does not follow the active setup");

  // The enable bit only moves after a converter control write; excitation never waits on it.
  chk_vref_steady: assert property (
    !$past(wr_adc) |=> $stable(vref_power_en))
    else $error("reference power moved without a write");
  chk_excite_indep: assert property (
    wr_adc && !$past(wr_io) |=> $stable(excite_a_magnitude) && $stable(excite_b_magnitude))
    else $error("excitation moved on a converter control write");
  chk_pins_on_adc_wr: assert property (
    wr_adc && !$past(wr_io) |=> $stable(excite_a_pin_select) && $stable(bridge_switch_enable))
    else $error("io control outputs moved on a converter control write");

  // Write follow-through for the io control fields, two edges after the strobe; then modulator reset and result valid, one edge after their cause.
  chk_shared_pin: assert property (
    wr_io && reg_wdata[7:4] == reg_wdata[3:0] |-> ##2 excite_a_pin_select == excite_b_pin_select)
    else $error("both sources could not share one pin");
  chk_excite_b_mag: assert property (
    wr_io |-> ##2 excite_b_magnitude == $past(reg_wdata[13:11], 2)
                 && excite_a_pin_select == $past(reg_wdata[3:0], 2))
    else $error("second magnitude or first pin does not follow the write");
  chk_gp_level: assert property (
    wr_io |-> ##2 gp_output_pins == ($past(reg_wdata[23:20], 2) & $past(reg_wdata[19:16], 2)))
    else $error("enabled outputs do not drive their data bits");
  chk_io_no_reset: assert property (
    wr_io && sync_n |=> !mod_filter_reset)
    else $error("io control write reset the modulator");
  chk_sync_release: assert property (
    sync_n && !wr_adc && !wr_cfg |=> !mod_filter_reset)
    else $error("modulator reset held without a cause");
  chk_result_pulse: assert property (
    1'b1 |=> result_valid == $past(sample_valid))
    else $error("result valid did not follow the sample by one cycle");
endmodule : afc_ctrl

`default_nettype wire
